// file: verilog/rsx_rx_signaling.v
// receive signaling extractor: capture, change of state, freeze,
// four-multiframe buffer, signaling stream and reinsertion
// assumes framer logic on clk delivers per-channel abcd and mf_end;
// backplane clock and sync arrive as asynchronous pins
`timescale 1ns/1ps
`include "rsx_defs.vh"

// Behaviour
// [RULE_01] registers capture signaling at every multiframe boundary
// [RULE_02] channel enables gate the latched change bit
// [RULE_03] integration needs three stable multiframes
// [RULE_04] masked change drives interrupt output low; the code drives it low only for a change with the IMASK bit set
// [RULE_05] one integration bit covers all channels
// [RULE_06] change status records every channel change
// [RULE_07] signaling stream out, serial data untouched
// [RULE_08] backplane runs at 1.544 or 2.048 MHz
// [RULE_09] ESF abcd sits in lower nibble
// [RULE_10] stream refreshes once per multiframe unless frozen
// [RULE_11] D4 repeats A and B in nibble
// [RULE_12] reinsertion aligns to the sync pin multiframe
// [RULE_13] reinsertion needs elastic store, no E1 at 1.544
// [RULE_14] reinsertion enabled per channel
// [RULE_15] T1 all-ones forces robbed bits per channel
// [RULE_16] freeze enable freezes on OOF, loss, realign
// [RULE_17] force bit freezes unconditionally
// [RULE_18] freeze indicator pin shows freeze
// [RULE_19] four-multiframe buffer gives three multiframe delay
// [RULE_20] hold frozen signaling after fault clears
// [RULE_21] registers hold last value during loss of sync
// [RULE_22] latched bit sticks until host clears it
module rsx_rx_signaling #(
    parameter [21:0] HOLD_ESF_CYC = `RSX_HOLD_ESF_CYC,
    parameter [21:0] HOLD_D4_CYC  = `RSX_HOLD_D4_CYC,
    parameter [21:0] HOLD_E1_CYC  = `RSX_HOLD_E1_CYC
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // framer side, same clock
    input  wire        cap_valid,
    input  wire [4:0]  cap_chan,
    input  wire [3:0]  cap_abcd,
    input  wire        mf_end,
    input  wire        oof_in,
    input  wire        carrier_loss_in,
    input  wire        realign_in,
    input  wire        rx_serial_data_in,
    // backplane pins
    input  wire        rx_backplane_clock,
    input  wire        rx_sync_pin,
    output reg         rx_serial_data_out,
    output reg         rx_signaling_stream_out,
    // indications
    output reg         interrupt_out_n,
    output reg         freeze_indicator_out
);

    reg  [7:0]   ctrl_q;
    reg          lstat_q;
    reg          imask_q;
    reg  [31:0]  cse_q;
    reg  [31:0]  rss_q;
    reg  [31:0]  rsi_q;
    reg  [23:0]  aoi_q;
    reg  [1:0]   wr_ptr_q;
    reg  [21:0]  hold_q;
    reg  [3:0]   buf_q [0:127];
    wire [127:0] stage_flat;
    wire [127:0] sig_flat;
    wire [31:0]  chg_vec;
    integer      i;

    wire integ_en = ctrl_q[`RSX_CTRL_INTEG];
    wire fe       = ctrl_q[`RSX_CTRL_FE];
    wire ff       = ctrl_q[`RSX_CTRL_FF];
    wire e1       = ctrl_q[`RSX_CTRL_E1];
    wire d4       = ctrl_q[`RSX_CTRL_D4];
    wire bp2048   = ctrl_q[`RSX_CTRL_BP2048];
    wire es_en    = ctrl_q[`RSX_CTRL_ESEN];
    wire upd      = mf_end && !oof_in;
    wire fault    = oof_in | carrier_loss_in | realign_in;
    // one global freeze for the whole channel set
    wire frozen   = ff | (fe & (fault | (hold_q != 22'd0))); // [RULE_16] [RULE_17]

    // per-channel capture, integration and change detection
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : ch
            reg  [3:0] stage_q;
            reg  [3:0] cand_q;
            reg  [3:0] val_q;
            reg  [1:0] cnt_q;
            wire       third = (stage_q == cand_q) && (cnt_q == 2'd2);
            // integration picks the value only on its third stable multiframe
            wire [3:0] acc = integ_en ? (third ? cand_q : val_q) : stage_q; // [RULE_03] [RULE_05]
            assign stage_flat[g*4 +: 4] = stage_q;
            assign sig_flat[g*4 +: 4]   = val_q;
            assign chg_vec[g]           = upd && (acc != val_q);
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_q <= 4'h0;
                    cand_q  <= 4'h0;
                    val_q   <= 4'h0;
                    cnt_q   <= 2'd0;
                end else begin
                    if (cap_valid && cap_chan == g)
                        stage_q <= cap_abcd;
                    if (upd) begin // [RULE_01] [RULE_21]
                        val_q <= acc;
                        if (stage_q != cand_q) begin
                            cand_q <= stage_q;
                            cnt_q  <= 2'd1;
                        end else if (cnt_q != 2'd3) begin
                            cnt_q <= cnt_q + 2'd1;
                        end
                    end
                end
            end
        end
    endgenerate

    // apb decode
    wire        setup  = psel && !penable;
    wire        wr_en  = psel && penable && pwrite && pready && !pslverr;
    wire [11:0] sigoff = paddr - `RSX_OFF_SIGREG;
    wire        in_sig = (paddr >= `RSX_OFF_SIGREG) && (paddr < `RSX_OFF_SIGEND);
    reg  [31:0] rd_d;
    reg         err_d;

    always @* begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            err_d = 1'b1;
        end else if (in_sig) begin
            rd_d[3:0] = sig_flat[sigoff[6:2]*4 +: 4];
            err_d     = pwrite;
        end else begin
            case (paddr)
                `RSX_OFF_CTRL:  rd_d[7:0] = ctrl_q;
                `RSX_OFF_LSTAT: rd_d[`RSX_COS_BIT] = lstat_q;
                `RSX_OFF_IMASK: rd_d[`RSX_COS_BIT] = imask_q;
                `RSX_OFF_CSE:   rd_d = cse_q;
                `RSX_OFF_RSS:   rd_d = rss_q;
                `RSX_OFF_RSI:   rd_d = rsi_q;
                `RSX_OFF_AOI:   rd_d[23:0] = aoi_q;
                `RSX_OFF_STAT:  rd_d[2:0] = {wr_ptr_q[0] & 1'b0, fault, frozen};
                default:        err_d = 1'b1;
            endcase
            if (pwrite && paddr == `RSX_OFF_STAT)
                err_d = 1'b1;
        end
    end

    // answer in the first access cycle: pready rises one edge after setup
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & err_d;
            prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    // control registers, sticky status, interrupt
    wire clr_ls = wr_en && paddr == `RSX_OFF_LSTAT && pwdata[`RSX_COS_BIT];
    wire [31:0] clr_rss = (wr_en && paddr == `RSX_OFF_RSS) ? pwdata : 32'h0000_0000;
    wire cos_set = |(chg_vec & cse_q); // [RULE_02]

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q          <= `RSX_CTRL_RST;
            lstat_q         <= 1'b0;
            imask_q         <= 1'b0;
            cse_q           <= `RSX_MASK_RST;
            rss_q           <= 32'h0000_0000;
            rsi_q           <= `RSX_MASK_RST;
            aoi_q           <= 24'h00_0000;
            interrupt_out_n <= 1'b1;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `RSX_OFF_CTRL:  ctrl_q  <= pwdata[7:0];
                    `RSX_OFF_IMASK: imask_q <= pwdata[`RSX_COS_BIT];
                    `RSX_OFF_CSE:   cse_q   <= pwdata;
                    `RSX_OFF_RSI:   rsi_q   <= pwdata;
                    `RSX_OFF_AOI:   aoi_q   <= pwdata[23:0];
                    default:        ;
                endcase
            end
            // set wins over a write-one clear in the same cycle
            lstat_q <= (lstat_q & ~clr_ls) | cos_set; // [RULE_22]
            rss_q   <= (rss_q & ~clr_rss) | chg_vec; // [RULE_06]
            interrupt_out_n <= ~(lstat_q & imask_q); // [RULE_04] [RULE_22]
        end
    end

    // freeze hold timer restarts while the fault lasts
    wire [21:0] hold_ld = e1 ? HOLD_E1_CYC : (d4 ? HOLD_D4_CYC : HOLD_ESF_CYC);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q               <= 22'd0;
            freeze_indicator_out <= 1'b0;
        end else begin
            if (fe && fault)
                hold_q <= hold_ld; // [RULE_20]
            else if (hold_q != 22'd0)
                hold_q <= hold_q - 22'd1; // [RULE_20]
            freeze_indicator_out <= frozen; // [RULE_18]
        end
    end

    // signaling buffer: four multiframe slots, the one after the write pointer (second oldest) is read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= 2'd0;
            for (i = 0; i < 128; i = i + 1)
                buf_q[i] <= 4'h0;
        end else if (mf_end && !frozen) begin // [RULE_10] [RULE_16]
            for (i = 0; i < 32; i = i + 1)
                buf_q[{wr_ptr_q, i[4:0]}] <= stage_flat[i*4 +: 4]; // [RULE_19]
            wr_ptr_q <= wr_ptr_q + 2'd1;
        end
    end

    // backplane pins: three stages, a change counts when two agree
    reg [2:0] bc_s;
    reg [2:0] sy_s;
    reg       bc_lvl_q;
    reg       sy_lvl_q;
    wire bc_rise = (bc_s[1] == bc_s[2]) && bc_s[2] && !bc_lvl_q;
    wire sy_rise = (sy_s[1] == sy_s[2]) && sy_s[2] && !sy_lvl_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bc_s     <= 3'b000;
            sy_s     <= 3'b000;
            bc_lvl_q <= 1'b0;
            sy_lvl_q <= 1'b0;
        end else begin
            bc_s <= {bc_s[1:0], rx_backplane_clock};
            sy_s <= {sy_s[1:0], rx_sync_pin};
            if (bc_s[1] == bc_s[2])
                bc_lvl_q <= bc_s[2];
            if (sy_s[1] == sy_s[2])
                sy_lvl_q <= sy_s[2];
        end
    end

    // backplane position counters
    reg  [7:0] pos_q;
    reg  [4:0] frame_q;
    reg  [2:0] m6_q;
    reg  [1:0] d6_q;
    reg        sync_pend_q;
    wire [7:0] pos_last = bp2048 ? `RSX_POS_2048 : `RSX_POS_1544; // [RULE_08]
    wire [4:0] fr_last  = e1 ? `RSX_FR_E1 : (d4 ? `RSX_FR_D4 : `RSX_FR_ESF);
    // T1 on a 1.544 backplane carries the F bit first
    wire       fbit     = !bp2048 && (pos_q == 8'd0);
    wire [7:0] bitpos   = bp2048 ? pos_q : (pos_q - 8'd1);
    wire [4:0] ts       = bitpos[7:3];
    wire [2:0] b        = bitpos[2:0];
    wire       ts16     = e1 && (ts == 5'd16) && (frame_q != 5'd0);
    wire [4:0] sel_ch   = ts16 ? (b[2] ? (frame_q + 5'd16) : frame_q) : ts;
    wire [3:0] abcd     = buf_q[{wr_ptr_q + 2'd1, sel_ch}]; // [RULE_19]
    wire       t1_ch    = !e1 && !fbit && (ts < 5'd24);
    wire       robbed   = t1_ch && (b == 3'd7) && (m6_q == 3'd5);
    // no E1 reinsertion into a 1.544 backplane
    wire       ri_ok    = es_en && !(e1 && !bp2048) && rsi_q[sel_ch]; // [RULE_13] [RULE_14]
    reg        ser_d;
    reg        sig_d;

    always @* begin
        sig_d = 1'b0;
        if (!fbit && b[2]) begin
            if (d4 && !e1)
                sig_d = b[0] ? abcd[2] : abcd[3]; // [RULE_11]
            else
                sig_d = abcd[~b[1:0]]; // [RULE_09] [RULE_07]
        end
        ser_d = rx_serial_data_in;
        if (robbed && aoi_q[ts])
            ser_d = 1'b1; // [RULE_15]
        else if (robbed && ri_ok)
            ser_d = abcd[~d6_q]; // [RULE_12]
        else if (ts16 && ri_ok)
            ser_d = abcd[~b[1:0]]; // [RULE_12]
    end

    // a sync edge realigns the next bit to frame 0, position 1
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q                   <= 8'd0;
            frame_q                 <= 5'd0;
            m6_q                    <= 3'd0;
            d6_q                    <= 2'd0;
            sync_pend_q             <= 1'b0;
            rx_serial_data_out      <= 1'b0;
            rx_signaling_stream_out <= 1'b0;
        end else begin
            if (sy_rise)
                sync_pend_q <= 1'b1;
            if (bc_rise) begin
                rx_serial_data_out      <= ser_d;
                rx_signaling_stream_out <= sig_d; // [RULE_07]
                if (sync_pend_q || sy_rise) begin // [RULE_12]
                    sync_pend_q <= 1'b0;
                    pos_q       <= 8'd1;
                    frame_q     <= 5'd0;
                    m6_q        <= 3'd0;
                    d6_q        <= 2'd0;
                end else if (pos_q != pos_last) begin
                    pos_q <= pos_q + 8'd1;
                end else begin
                    pos_q <= 8'd0;
                    if (frame_q == fr_last) begin
                        frame_q <= 5'd0;
                        m6_q    <= 3'd0;
                        d6_q    <= 2'd0;
                    end else begin
                        frame_q <= frame_q + 5'd1;
                        if (m6_q == 3'd5) begin
                            m6_q <= 3'd0;
                            d6_q <= d6_q + 2'd1;
                        end else begin
                            m6_q <= m6_q + 3'd1;
                        end
                    end
                end
            end
        end
    end

endmodule

// file: verilog/rsx_defs.vh
// constants for the receive signaling extractor
// assumes a 200 MHz core clock and a 32-bit APB slave
`ifndef RSX_DEFS_VH
`define RSX_DEFS_VH

`define RSX_CLK_MHZ 200

// register byte offsets
`define RSX_OFF_CTRL   12'h000
`define RSX_OFF_LSTAT  12'h004
`define RSX_OFF_IMASK  12'h008
`define RSX_OFF_CSE    12'h00c
`define RSX_OFF_RSS    12'h010
`define RSX_OFF_RSI    12'h014
`define RSX_OFF_AOI    12'h018
`define RSX_OFF_STAT   12'h01c
`define RSX_OFF_SIGREG 12'h040
`define RSX_OFF_SIGEND 12'h0c0

// control register fields
`define RSX_CTRL_INTEG  0
`define RSX_CTRL_FE     1
`define RSX_CTRL_FF     2
`define RSX_CTRL_E1     4
`define RSX_CTRL_D4     5
`define RSX_CTRL_BP2048 6
`define RSX_CTRL_ESEN   7
`define RSX_CTRL_W      8
`define RSX_CTRL_RST    8'h00

// latched status / mask field
`define RSX_COS_BIT 3

// reset values
`define RSX_MASK_RST 32'h0000_0000
`define RSX_INT_CHANS 32'hffff_ffff

// last frame index of a multiframe
`define RSX_FR_ESF 5'd23
`define RSX_FR_D4  5'd11
`define RSX_FR_E1  5'd15

// last bit position of a backplane frame
`define RSX_POS_1544 8'd192
`define RSX_POS_2048 8'd255

// freeze hold after the fault clears, in microseconds
`define RSX_HOLD_ESF_US 9000
`define RSX_HOLD_D4_US  4500
`define RSX_HOLD_E1_US  6000
// cycle counts are the microsecond figures times the core clock in MHz
`define RSX_HOLD_ESF_CYC 22'd1800000
`define RSX_HOLD_D4_CYC  22'd900000
`define RSX_HOLD_E1_CYC  22'd1200000

`endif

// file: verif/rsx_monitor.sv
// port checker for the receive signaling extractor
// assumes it is bound onto rsx_rx_signaling, apb on clk
`timescale 1ns/1ps
module rsx_monitor #(
    parameter [21:0] HOLD_ESF_CYC = 22'd50,
    parameter [21:0] HOLD_D4_CYC  = 22'd25,
    parameter [21:0] HOLD_E1_CYC  = 22'd35
) (
    // clock and reset
    input wire        clk,
    input wire        rst_n,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // framer side
    input wire        mf_end,
    input wire        oof_in,
    input wire        carrier_loss_in,
    input wire        realign_in,
    // indications
    input wire        interrupt_out_n,
    input wire        freeze_indicator_out
);
    wire        acc_w  = psel && penable && pready && pwrite;
    wire        wr_int = acc_w && (paddr == 12'h004 || paddr == 12'h008);
    wire        fault  = oof_in || carrier_loss_in || realign_in;
    logic [7:0]  ctrl_q;
    logic [21:0] quiet_q;
    // hold limit follows the framing mode that software last wrote
    wire [21:0] hold = ctrl_q[4] ? HOLD_E1_CYC : (ctrl_q[5] ? HOLD_D4_CYC : HOLD_ESF_CYC);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= 8'h00;
            quiet_q <= 22'h0;
        end else begin
            if (acc_w && paddr == 12'h000)
                ctrl_q <= pwdata[7:0];
            quiet_q <= fault ? 22'h0 : quiet_q + 22'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_int_clear;
        (acc_w && paddr == 12'h004 && pwdata[3] && !mf_end) ##1 !mf_end |=> interrupt_out_n;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt stuck after clear");
    property p_int_mask;
        (acc_w && paddr == 12'h008 && !pwdata[3]) |=> ##1 interrupt_out_n;
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("interrupt active while masked");
    property p_int_cause;
        $fell(interrupt_out_n) |-> $past(mf_end, 2) || $past(acc_w && paddr == 12'h008 && pwdata[3], 2);
    endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt fell without cause");
    property p_int_hold;
        (!interrupt_out_n && !wr_int && !$past(wr_int)) |=> !interrupt_out_n;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt released by itself");
    property p_force_hold;
        ctrl_q[2] [*3] |-> freeze_indicator_out;
    endproperty
    a_force_hold: assert property (p_force_hold) else $error("forced freeze not shown");
    property p_fault_frz;
        (ctrl_q[1] && fault) |-> ##[1:4] freeze_indicator_out;
    endproperty
    a_fault_frz: assert property (p_fault_frz) else $error("fault did not freeze");
    property p_frz_hold;
        ($fell(freeze_indicator_out) && ctrl_q[1]) |-> (quiet_q + 22'd2 >= hold);
    endproperty
    a_frz_hold: assert property (p_frz_hold) else $error("freeze released too early");
    property p_ro_refuse;
        (acc_w && paddr >= 12'h040 && paddr < 12'h0c0) |-> pslverr;
    endproperty
    a_ro_refuse: assert property (p_ro_refuse) else $error("signaling register write accepted");
endmodule

bind rsx_rx_signaling rsx_monitor #(
    .HOLD_ESF_CYC(HOLD_ESF_CYC), .HOLD_D4_CYC(HOLD_D4_CYC), .HOLD_E1_CYC(HOLD_E1_CYC)
) rsx_monitor_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .mf_end(mf_end),
    .oof_in(oof_in), .carrier_loss_in(carrier_loss_in), .realign_in(realign_in),
    .interrupt_out_n(interrupt_out_n), .freeze_indicator_out(freeze_indicator_out)
);

// file: verif/rsx_bp_model.sv
// backplane model: free running system clock, multiframe sync, serial data
// assumes an elastic store sits between line and backplane
`timescale 1ns/1ps
module rsx_bp_model #(
    parameter int HALF_NS = 40,
    parameter int MF_BITS = 4632
) (
    // backplane pins
    output logic rx_backplane_clock,
    output logic rx_sync_pin,
    output logic rx_serial_data_in
);
    int n;

    initial begin
        rx_backplane_clock = 1'b0;
        rx_sync_pin        = 1'b0;
        rx_serial_data_in  = 1'b0;
        n                  = 0;
        forever begin
            #(HALF_NS);
            rx_backplane_clock = ~rx_backplane_clock;
            if (!rx_backplane_clock) begin
                // data moves on seven bits of every eight so a stuck path cannot pass
                rx_serial_data_in = n[0] ^ n[3];
                rx_sync_pin       = (n % MF_BITS == 0);
                n++;
            end
        end
    end
endmodule

// file: verif/tb.sv
// self-checking bench for the receive signaling extractor
// assumes short hold parameters and the backplane model on the pins
`timescale 1ns/1ps
`include "rsx_defs.vh"
module tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        cap_valid, mf_end, oof_in, carrier_loss_in, realign_in;
    logic [4:0]  cap_chan;
    logic [3:0]  cap_abcd;
    logic        bp_clk, bp_sync, bp_din, ser_out, sig_out, irq_n, frz;
    int          err_total, samples_checked, ones, sbad;
    int          hold [3] = '{50, 25, 35};
    logic [7:0]  mode [3] = '{8'h02, 8'h22, 8'h12};

    rsx_rx_signaling #(
        .HOLD_ESF_CYC(22'd50), .HOLD_D4_CYC(22'd25), .HOLD_E1_CYC(22'd35)
    ) rsx_rx_signaling_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cap_valid(cap_valid), .cap_chan(cap_chan), .cap_abcd(cap_abcd), .mf_end(mf_end),
        .oof_in(oof_in), .carrier_loss_in(carrier_loss_in), .realign_in(realign_in),
        .rx_serial_data_in(bp_din), .rx_backplane_clock(bp_clk), .rx_sync_pin(bp_sync),
        .rx_serial_data_out(ser_out), .rx_signaling_stream_out(sig_out),
        .interrupt_out_n(irq_n), .freeze_indicator_out(frz)
    );
    rsx_bp_model rsx_bp_model_inst (
        .rx_backplane_clock(bp_clk), .rx_sync_pin(bp_sync), .rx_serial_data_in(bp_din)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic w(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16) begin
            err_total++;
            report_and_stop;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one 193-bit frame: ones on the stream, and serial bits that differ from the input
    task automatic bp_frame(output int n1, output int nbad);
        logic dv;
        n1   = 0;
        nbad = 0;
        repeat (193) begin
            @(posedge bp_clk);
            dv = bp_din;
            @(negedge bp_clk);
            n1   += sig_out;
            nbad += (ser_out !== dv);
        end
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic cap(input logic [4:0] c, input logic [3:0] v);
        @(posedge clk);
        cap_valid <= 1'b1;
        cap_chan  <= c;
        cap_abcd  <= v;
        @(posedge clk);
        cap_valid <= 1'b0;
    endtask

    task automatic mf(input int k);
        repeat (k) begin
            @(posedge clk);
            mf_end <= 1'b1;
            @(posedge clk);
            mf_end <= 1'b0;
        end
    endtask

    initial begin
        #400000;
        err_total++;
        report_and_stop;
    end

    initial begin
        {rst_n, psel, penable, pwrite, cap_valid, mf_end} = 6'h0;
        {oof_in, carrier_loss_in, realign_in} = 3'h0;
        {paddr, pwdata, cap_chan, cap_abcd} = 53'h0;
        err_total = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`RSX_OFF_CTRL, 32'h0);
        rdc(`RSX_OFF_IMASK, `RSX_MASK_RST);
        rdc(12'h020, 32'h0);
        chk1(err, 1'b1);
        apb(1'b1, `RSX_OFF_SIGREG, 32'hf);
        chk1(err, 1'b1);
        apb(1'b1, `RSX_OFF_STAT, 32'h1);
        chk1(err, 1'b1);
        // one enabled and one disabled channel change together
        apb(1'b1, `RSX_OFF_CSE, 32'h20);
        apb(1'b1, `RSX_OFF_IMASK, 32'h8);
        cap(5'd5, 4'ha);
        cap(5'd6, 4'h3);
        mf(1);
        w(3);
        chk1(irq_n, 1'b0);
        rdc(`RSX_OFF_SIGREG + 12'd20, 32'ha);
        rdc(`RSX_OFF_SIGREG + 12'd24, 32'h3);
        rdc(`RSX_OFF_RSS, 32'h60);
        rdc(`RSX_OFF_LSTAT, 32'h8);
        apb(1'b1, `RSX_OFF_RSS, 32'h60);
        apb(1'b1, `RSX_OFF_LSTAT, 32'h8);
        w(3);
        chk1(irq_n, 1'b1);
        cap(5'd6, 4'h5);
        mf(1);
        rdc(`RSX_OFF_RSS, 32'h40);
        rdc(`RSX_OFF_LSTAT, 32'h0);
        // loss of sync: boundary ignored, value kept
        oof_in <= 1'b1;
        cap(5'd5, 4'h3);
        mf(1);
        oof_in <= 1'b0;
        rdc(`RSX_OFF_SIGREG + 12'd20, 32'ha);
        mf(1);
        w(3);
        chk1(irq_n, 1'b0);
        apb(1'b1, `RSX_OFF_IMASK, 32'h0);
        w(3);
        chk1(irq_n, 1'b1);
        rdc(`RSX_OFF_LSTAT, 32'h8);
        apb(1'b1, `RSX_OFF_LSTAT, 32'h8);
        apb(1'b1, `RSX_OFF_CTRL, 32'h1);
        cap(5'd7, 4'h9);
        mf(2);
        rdc(`RSX_OFF_SIGREG + 12'd28, 32'h0);
        mf(1);
        rdc(`RSX_OFF_SIGREG + 12'd28, 32'h9);
        apb(1'b1, `RSX_OFF_CTRL, 32'h4);
        w(3);
        chk1(frz, 1'b1);
        rdc(`RSX_OFF_STAT, 32'h1);
        apb(1'b1, `RSX_OFF_CTRL, 32'h0);
        w(3);
        chk1(frz, 1'b0);
        // each fault source in its own framing mode
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, `RSX_OFF_CTRL, {24'h0, mode[m]});
            {realign_in, carrier_loss_in, oof_in} <= 3'b001 << m;
            w(5);
            chk1(frz, 1'b1);
            {realign_in, carrier_loss_in, oof_in} <= 3'b000;
            w(hold[m] - 10);
            chk1(frz, 1'b1);
            w(20);
            chk1(frz, 1'b0);
        end
        // ones per frame do not depend on frame alignment
        apb(1'b1, `RSX_OFF_CTRL, 32'h0);
        cap(5'd1, 4'hf);
        mf(4);
        bp_frame(ones, sbad);
        chk(ones, 32'd10);
        chk(sbad, 32'd0);
        apb(1'b1, `RSX_OFF_CTRL, 32'h20);
        bp_frame(ones, sbad);
        chk(ones, 32'd8);
        chk(sbad, 32'd0);
        report_and_stop;
    end
endmodule
